// ==== sim/fmac_conv_model.sv ====
// Converter stand-in answering each start promptly or slowly
`timescale 1ns/1ps
module fmac_conv_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic convStart,
    input wire logic slow,
    output logic convDone
);
    logic busy_q; // Conversion under way
    logic [3:0] wait_q; // Cycles left before done
    wire fin = busy_q && wait_q == 4'h0; // Last busy cycle
    wire [3:0] load = slow ? 4'h9 : 4'h0; // Conversion length
    wire [3:0] wait_d = convStart ? load : wait_q - {3'h0, busy_q && !fin};
    // Count down, then pulse done for one cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            wait_q <= 4'h0;
            convDone <= 1'b0;
        end else begin
            convDone <= fin;
            busy_q <= convStart || (busy_q && !fin);
            wait_q <= wait_d;
        end
    end
endmodule

// ==== sim/fmac_top_props.sv ====
// Port assertions for the register bank
`timescale 1ns/1ps
module fmac_top_props
    import fmac_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regReset,
    input wire logic watchdogExpire,
    input wire logic inputOvervoltFault,
    input wire logic thermalShutdownFault,
    input wire logic batteryOvervoltFault,
    input wire logic safetyTimerExpired,
    input wire logic systemShortFault,
    input wire logic stepdownOutputFaultStatus,
    input wire logic convStart,
    input wire logic [2:0] convChannel,
    input wire fmac_pkg::fmac_res_t convResolution,
    input wire logic convEnabled,
    input wire logic convOneShot,
    input wire logic intPulse
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic [5:0] lvl_q; // Fault levels one cycle ago
    logic [7:0] mask_q; // Shadow of the mask register
    logic [7:0] chOff_q; // Shadow of the channel disables
    wire [5:0] lvl = {inputOvervoltFault, thermalShutdownFault,
        batteryOvervoltFault, safetyTimerExpired, systemShortFault,
        stepdownOutputFaultStatus}; // Mask bit order
    wire [5:0] open = ~{mask_q[7:3], mask_q[0]}; // Unmasked sources
    wire [5:0] evt = {lvl[5:1] & ~lvl_q[5:1], lvl[0] ^ lvl_q[0]} & open;
    wire wrMask = regWrEn && regAddr == FMAC_ADDR_FAULT_MASK;
    wire wrCh = regWrEn && regAddr == FMAC_ADDR_CH_OFF;
    wire [7:0] mask_d = regReset ? 8'h00 : wrMask ? regWrData : mask_q;
    wire [7:0] chOff_d = regReset ? 8'h00 : wrCh ? regWrData : chOff_q;
    // Shadows follow host writes and register reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lvl_q <= 6'h00;
            mask_q <= 8'h00;
            chOff_q <= 8'h00;
        end else begin
            lvl_q <= lvl;
            mask_q <= mask_d;
            chOff_q <= chOff_d;
        end
    end
    property p_step;
        $changed(stepdownOutputFaultStatus) && !mask_q[0] |=> intPulse;
    endproperty
    a_step: assert property (p_step) else $error("no step-down pulse");
    property p_any;
        (|evt) |=> intPulse;
    endproperty
    a_any: assert property (p_any)
        else $error("no fault pulse");
    property p_quiet;
        !(|evt) && !convOneShot && !$past(convOneShot) |=> !intPulse;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray pulse");
    property p_rsv;
        regRdEn && regAddr == FMAC_ADDR_CONV_CTRL |=> regRdData[3:0] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_wdog;
        watchdogExpire && !regWrEn && !regReset
            |=> !convEnabled && $stable(convOneShot)
            && $stable(convResolution);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog effect");
    property p_wr;
        regWrEn && regAddr == FMAC_ADDR_CONV_CTRL && !regReset
            |=> convOneShot == $past(regWrData[6])
            && convResolution == $past(regWrData[5:4]);
    endproperty
    a_wr: assert property (p_wr) else $error("control write lost");
    property p_rst;
        regReset |=> !convEnabled && !convOneShot
            && convResolution == FMAC_RES_12BIT;
    endproperty
    a_rst: assert property (p_rst) else $error("control reset");
    property p_chan;
        convStart |-> convChannel != 3'h1 && !chOff_q[convChannel];
    endproperty
    a_chan: assert property (p_chan) else $error("off channel run");
endmodule
bind fmac_top fmac_top_props fmac_top_props_i (.mclk, .nrst, .regWrEn,
    .regRdEn, .regAddr, .regWrData, .regRdData, .regReset,
    .watchdogExpire, .inputOvervoltFault, .thermalShutdownFault,
    .batteryOvervoltFault, .safetyTimerExpired, .systemShortFault,
    .stepdownOutputFaultStatus, .convStart, .convChannel,
    .convResolution, .convEnabled, .convOneShot, .intPulse);

// ==== sim/fmac_top_tb.sv ====
// Self-checking bench for the register bank
`timescale 1ns/1ps
module fmac_top_tb;
    import fmac_pkg::*;
    logic mclk, nrst, regWrEn, regRdEn, regReset, watchdogExpire;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [5:0] fault; // Fault levels in mask bit order
    logic convDoneIrqMask, convDone, convStart, convEnabled;
    logic convOneShot, convPassDone, intPulse, slow, mark;
    logic [2:0] convChannel;
    fmac_res_t convResolution;
    logic [31:0] rng; // Random state
    logic rdLate, irqLate; // A result is due now
    logic [7:0] rdQ[$], irqQ[$], chQ[$]; // Expected results
    int nFail, checksDone;
    fmac_top fmac_top_i (.mclk, .nrst, .regWrEn, .regRdEn, .regAddr,
        .regWrData, .regRdData, .regReset, .watchdogExpire,
        .inputOvervoltFault(fault[5]), .thermalShutdownFault(fault[4]),
        .batteryOvervoltFault(fault[3]), .safetyTimerExpired(fault[2]),
        .systemShortFault(fault[1]), .stepdownOutputFaultStatus(fault[0]),
        .convDoneIrqMask, .convDone, .convStart, .convChannel,
        .convResolution, .convEnabled, .convOneShot, .convPassDone,
        .intPulse);
    fmac_conv_model fmac_conv_model_i (.mclk, .nrst, .convStart, .slow,
        .convDone);
    // Free-running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic endSim();
        $display("checks=%0d fails=%0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Strobe for one cycle, then one idle cycle before the next request
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrEn <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rdQ.push_back(exp);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRdEn <= 1'b0;
        @(posedge mclk);
    endtask
    // Raise one fault with its own mask bit set or clear
    task automatic hit(input int j, input logic m);
        logic [7:0] b;
        b = 8'h01 << (j == 0 ? 0 : j + 2);
        fault[j] <= 1'b0;
        repeat (3) @(posedge mclk);
        wr(FMAC_ADDR_FAULT_MASK, m ? b : ~b);
        fault[j] <= 1'b1;
        mark <= 1'b1;
        irqQ.push_back({7'h00, !m});
        @(posedge mclk);
        mark <= 1'b0;
    endtask
    task automatic pushScan(input logic [7:0] off, input int reps);
        for (int r = 0; r < reps; r++) begin
            for (int c = 7; c >= 0; c--) begin
                if (c != 1 && !off[c])
                    chQ.push_back(8'(c));
            end
        end
    endtask
    // Wait for the scan to finish, counting interrupt pulses
    task automatic waitScan(input logic off, output int k, output int p);
        int n;
        k = 0;
        p = 0;
        n = 0;
        while (chQ.size() > 0 || (off && convEnabled !== 1'b0)) begin
            @(posedge mclk);
            k += int'(intPulse === 1'b1);
            p += int'(convPassDone === 1'b1);
            n++;
            if (n > 1000) begin
                nFail++;
                endSim();
            end
        end
        repeat (3) begin
            @(posedge mclk);
            k += int'(intPulse === 1'b1);
            p += int'(convPassDone === 1'b1);
        end
    endtask
    // Result watcher: compares each result with the oldest note
    always @(posedge mclk) begin
        if (rdLate)
            chk(regRdData, rdQ.pop_front());
        if (irqLate)
            chk({7'h00, intPulse}, irqQ.pop_front());
        if (convStart === 1'b1 && chQ.size() > 0)
            chk({5'h00, convChannel}, chQ.pop_front());
        rdLate <= regRdEn;
        irqLate <= mark;
    end
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] im; // Implemented bits of the register under test
        int k;
        int p;
        nrst = 1'b0;
        {regWrEn, regRdEn, regReset, watchdogExpire} = 4'h0;
        {convDoneIrqMask, slow, mark, rdLate, irqLate} = 5'h00;
        regAddr = 8'h00;
        regWrData = 8'h00;
        fault = 6'h00;
        rng = 32'h0000001e;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(FMAC_ADDR_FAULT_MASK, 8'h00);
        rd(FMAC_ADDR_CONV_CTRL, 8'h30);
        rd(FMAC_ADDR_CH_OFF, 8'h00);
        rd(8'h17, 8'h00);
        for (int i = 0; i < 9; i++) begin
            rng = xs(rng);
            a = FMAC_ADDR_FAULT_MASK + 8'(i % 3);
            d = rng[7:0] & 8'h7f;
            im = i % 3 == 0 ? FMAC_IMPL_FAULT_MASK
                : i % 3 == 1 ? FMAC_IMPL_CONV_CTRL : FMAC_IMPL_CH_OFF;
            wr(a, d);
            rd(a, d & im);
        end
        for (int j = 0; j < 6; j++) begin
            hit(j, 1'b0);
            hit(j, 1'b1);
        end
        wr(FMAC_ADDR_CONV_CTRL, 8'hdf);
        watchdogExpire <= 1'b1;
        @(posedge mclk);
        watchdogExpire <= 1'b0;
        rd(FMAC_ADDR_CONV_CTRL, 8'h50);
        wr(FMAC_ADDR_CH_OFF, 8'hff);
        wr(FMAC_ADDR_FAULT_MASK, 8'hff);
        regReset <= 1'b1;
        @(posedge mclk);
        regReset <= 1'b0;
        rd(FMAC_ADDR_FAULT_MASK, 8'h00);
        rd(FMAC_ADDR_CONV_CTRL, 8'h30);
        rd(FMAC_ADDR_CH_OFF, 8'h00);
        // One-shot pass with the done interrupt open, then masked
        for (int m = 0; m < 2; m++) begin
            convDoneIrqMask <= m[0];
            pushScan(8'h54, 1);
            wr(FMAC_ADDR_CH_OFF, 8'h54);
            wr(FMAC_ADDR_CONV_CTRL, 8'hc0);
            waitScan(1'b1, k, p);
            chk(8'(k), {7'h00, !m[0]});
            chk(8'(p), 8'h01);
            rd(FMAC_ADDR_CONV_CTRL, 8'h40);
        end
        slow <= 1'b1;
        pushScan(8'h81, 2);
        wr(FMAC_ADDR_CH_OFF, 8'h81);
        wr(FMAC_ADDR_CONV_CTRL, 8'h80);
        waitScan(1'b0, k, p);
        chk(8'(k), 8'h00);
        chk(8'(p), 8'h01);
        wr(FMAC_ADDR_CONV_CTRL, 8'h00);
        // Converter off: no further starts
        k = 0;
        repeat (20) begin
            @(posedge mclk);
            k += int'(convStart === 1'b1);
        end
        chk(8'(k), 8'h00);
        chk(8'(chQ.size()), 8'h00);
        endSim();
    end
endmodule

// ==== verilog/fmac_pkg.sv ====
// Constants and types shared by the converter control register bank
package fmac_pkg;
    // Register offsets on the serial register port
    localparam logic [7:0] FMAC_ADDR_FAULT_MASK = 8'h14;
    localparam logic [7:0] FMAC_ADDR_CONV_CTRL = 8'h15;
    localparam logic [7:0] FMAC_ADDR_CH_OFF = 8'h16;
    // Reset values
    localparam logic [7:0] FMAC_RST_FAULT_MASK = 8'h00;
    localparam logic [7:0] FMAC_RST_CONV_CTRL = 8'h30;
    localparam logic [7:0] FMAC_RST_CH_OFF = 8'h00;
    // Implemented bits; the rest are reserved and read as zero
    localparam logic [7:0] FMAC_IMPL_FAULT_MASK = 8'hf9;
    localparam logic [7:0] FMAC_IMPL_CONV_CTRL = 8'hf0;
    localparam logic [7:0] FMAC_IMPL_CH_OFF = 8'hfd;
    localparam logic [7:0] FMAC_ZERO_BYTE = 8'h00;
    // Fault mask bit positions
    localparam int unsigned FMAC_INPUT_OVERVOLT_BIT = 7;
    localparam int unsigned FMAC_THERMAL_SHUTDOWN_BIT = 6;
    localparam int unsigned FMAC_BATTERY_OVERVOLT_BIT = 5;
    localparam int unsigned FMAC_SAFETY_TIMER_BIT = 4;
    localparam int unsigned FMAC_SYSTEM_SHORT_BIT = 3;
    localparam int unsigned FMAC_STEPDOWN_FAULT_BIT = 0;
    // Converter control field positions
    localparam int unsigned FMAC_CONV_EN_BIT = 7;
    localparam int unsigned FMAC_CONV_RATE_BIT = 6;
    localparam int unsigned FMAC_CONV_RES_HI = 5;
    localparam int unsigned FMAC_CONV_RES_LO = 4;
    // Channel disable bit positions
    localparam int unsigned FMAC_CH_BUS_CURRENT = 7;
    localparam int unsigned FMAC_CH_CHARGE_CURRENT = 6;
    localparam int unsigned FMAC_CH_BUS_VOLTAGE = 5;
    localparam int unsigned FMAC_CH_BATTERY_VOLTAGE = 4;
    localparam int unsigned FMAC_CH_SYSTEM_VOLTAGE = 3;
    localparam int unsigned FMAC_CH_THERMISTOR = 2;
    localparam int unsigned FMAC_CH_DIE_TEMP = 0;
    // Channel scan: first and last index
    localparam logic [2:0] FMAC_CH_FIRST = 3'h7;
    localparam logic [2:0] FMAC_CH_LAST = 3'h0;
    // Effective resolution codes
    typedef enum logic [1:0] {
        FMAC_RES_15BIT = 2'h0,
        FMAC_RES_14BIT = 2'h1,
        FMAC_RES_13BIT = 2'h2,
        FMAC_RES_12BIT = 2'h3
    } fmac_res_t;
    // Scan sequencer states, one-hot
    typedef enum logic [2:0] {
        FMAC_SEQ_IDLE = 3'h1,
        FMAC_SEQ_SCAN = 3'h2,
        FMAC_SEQ_WAIT = 3'h4
    } fmac_seq_state_t;
endpackage

// ==== verilog/fmac_seq.sv ====
// Channel scan sequencer for the monitoring converter
`timescale 1ns/1ps
module fmac_seq
    import fmac_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    fmac_seq_if.seq ctl,
    input wire logic convDone,
    output logic convStart,
    output logic [2:0] convChannel
);
    import fmac_pkg::*;

    fmac_seq_state_t state_q, state_d; // Sequencer state
    logic [2:0] ptr_q, ptr_d;          // Channel under scan
    logic start_q, start_d;            // Start pulse to converter
    logic done_q, done_d;              // End of pass pulse
    logic shotEnd_q, shotEnd_d;        // End of a one-shot pass

    // Channel wanted: not disabled and not the reserved slot
    wire chWanted = ~ctl.chOff[ptr_q] & FMAC_IMPL_CH_OFF[ptr_q];
    wire lastCh = (ptr_q == FMAC_CH_LAST);

    // Next state: skip disabled channels, wrap or stop at pass end
    always_comb begin
        state_d = state_q;
        ptr_d = ptr_q;
        start_d = 1'b0;
        done_d = 1'b0;
        shotEnd_d = 1'b0;
        case (state_q)
            FMAC_SEQ_IDLE: begin
                ptr_d = FMAC_CH_FIRST;
                // Stale enable in the cycle a one-shot pass ends
                if (ctl.enable && !shotEnd_q) begin
                    state_d = FMAC_SEQ_SCAN;
                end
            end
            FMAC_SEQ_SCAN: begin
                if (!ctl.enable) begin
                    state_d = FMAC_SEQ_IDLE;
                end else if (chWanted) begin
                    start_d = 1'b1;
                    state_d = FMAC_SEQ_WAIT;
                end else if (lastCh) begin
                    done_d = 1'b1;
                    shotEnd_d = ctl.oneShot;
                    ptr_d = FMAC_CH_FIRST;
                    // Continuous rate wraps, one-shot stops
                    state_d = ctl.oneShot ? FMAC_SEQ_IDLE
                                          : FMAC_SEQ_SCAN;
                end else begin
                    ptr_d = ptr_q - 3'h1;
                end
            end
            FMAC_SEQ_WAIT: begin
                if (!ctl.enable) begin
                    state_d = FMAC_SEQ_IDLE;
                end else if (convDone) begin
                    if (lastCh) begin
                        done_d = 1'b1;
                        shotEnd_d = ctl.oneShot;
                        ptr_d = FMAC_CH_FIRST;
                        state_d = ctl.oneShot ? FMAC_SEQ_IDLE
                                              : FMAC_SEQ_SCAN;
                    end else begin
                        ptr_d = ptr_q - 3'h1;
                        state_d = FMAC_SEQ_SCAN;
                    end
                end
            end
            default: begin
                state_d = FMAC_SEQ_IDLE;
                ptr_d = FMAC_CH_FIRST;
            end
        endcase
    end

    // State registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= FMAC_SEQ_IDLE;
            ptr_q <= FMAC_CH_FIRST;
            start_q <= 1'b0;
            done_q <= 1'b0;
            shotEnd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ptr_q <= ptr_d;
            start_q <= start_d;
            done_q <= done_d;
            shotEnd_q <= shotEnd_d;
        end
    end

    // Outputs from flip-flops
    assign convStart = start_q;
    assign convChannel = ptr_q;
    assign ctl.passDone = done_q;
    assign ctl.oneShotEnd = shotEnd_q;
endmodule

// ==== verilog/fmac_seq_if.sv ====
// Carrier between the register bank and the scan sequencer
`timescale 1ns/1ps
interface fmac_seq_if;
    logic enable;        // Converter enabled
    logic oneShot;       // Single pass when high
    logic [7:0] chOff;   // Per-channel skip bits
    logic passDone;      // One-cycle pulse at end of a pass
    logic oneShotEnd;    // Pass done in one-shot rate
    modport regs (output enable, output oneShot, output chOff,
                  input passDone, input oneShotEnd);
    modport seq (input enable, input oneShot, input chOff,
                 output passDone, output oneShotEnd);
endinterface

// ==== verilog/fmac_top.sv ====
// Fault mask, converter control and channel disable register bank
`timescale 1ns/1ps
module fmac_top
    import fmac_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    // Register port from the serial bus slave
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Soft resets
    input wire logic regReset,
    input wire logic watchdogExpire,
    // Fault levels from the charger
    input wire logic inputOvervoltFault,
    input wire logic thermalShutdownFault,
    input wire logic batteryOvervoltFault,
    input wire logic safetyTimerExpired,
    input wire logic systemShortFault,
    input wire logic stepdownOutputFaultStatus,
    // Conversion-done mask kept in a neighbouring register
    input wire logic convDoneIrqMask,
    // Analog converter handshake
    input wire logic convDone,
    output logic convStart,
    output logic [2:0] convChannel,
    output fmac_pkg::fmac_res_t convResolution,
    output logic convEnabled,
    output logic convOneShot,
    output logic convPassDone,
    // Shared interrupt pulse
    output logic intPulse
);
    import fmac_pkg::*;

    fmac_seq_if seqBus();

    // Stored registers, implemented bits only
    logic [7:0] faultMask_q, faultMask_d;
    logic [7:0] convCtrl_q, convCtrl_d;
    logic [7:0] chOff_q, chOff_d;
    logic [7:0] rdData_q, rdData_d;
    logic intPulse_q, intPulse_d;
    // Previous fault levels for edge detection
    logic [4:0] faultPrev_q;
    logic stepdownPrev_q;

    // Address decode
    wire selMask = (regAddr == FMAC_ADDR_FAULT_MASK);
    wire selCtrl = (regAddr == FMAC_ADDR_CONV_CTRL);
    wire selChOff = (regAddr == FMAC_ADDR_CH_OFF);
    wire wrMask = regWrEn & selMask;
    wire wrCtrl = regWrEn & selCtrl;
    wire wrChOff = regWrEn & selChOff;

    // Write data with reserved bits dropped
    wire [7:0] wrMaskVal = regWrData & FMAC_IMPL_FAULT_MASK;
    wire [7:0] wrCtrlVal = regWrData & FMAC_IMPL_CONV_CTRL;
    wire [7:0] wrChOffVal = regWrData & FMAC_IMPL_CH_OFF;

    // Individual mask bits
    wire inputOvervoltIrqMask = faultMask_q[FMAC_INPUT_OVERVOLT_BIT];
    wire thermalShutdownIrqMask = faultMask_q[FMAC_THERMAL_SHUTDOWN_BIT];
    wire batteryOvervoltIrqMask = faultMask_q[FMAC_BATTERY_OVERVOLT_BIT];
    wire safetyTimerIrqMask = faultMask_q[FMAC_SAFETY_TIMER_BIT];
    wire systemShortIrqMask = faultMask_q[FMAC_SYSTEM_SHORT_BIT];
    wire stepdownOutputFaultIrqMask = faultMask_q[FMAC_STEPDOWN_FAULT_BIT];

    // Current fault levels, same order as faultPrev_q
    wire [4:0] faultNow = {inputOvervoltFault, thermalShutdownFault,
                           batteryOvervoltFault, safetyTimerExpired,
                           systemShortFault};
    wire [4:0] faultRise = faultNow & ~faultPrev_q;

    // Gated fault events
    wire irqInputOvervolt = faultRise[4] & ~inputOvervoltIrqMask;
    wire irqThermal = faultRise[3] & ~thermalShutdownIrqMask;
    wire irqBatteryOvervolt = faultRise[2] & ~batteryOvervoltIrqMask;
    wire irqSafetyTimer = faultRise[1] & ~safetyTimerIrqMask;
    wire irqSystemShort = faultRise[0] & ~systemShortIrqMask;
    // Any change of the step-down status counts as an event
    wire stepdownEvent = stepdownOutputFaultStatus ^ stepdownPrev_q;
    wire irqStepdown = stepdownEvent & ~stepdownOutputFaultIrqMask;
    // Conversion done only reported at end of a one-shot pass
    wire irqConvDone = seqBus.oneShotEnd & ~convDoneIrqMask;

    // Control fields seen by the sequencer and the converter
    wire convEn = convCtrl_q[FMAC_CONV_EN_BIT];
    wire convRate = convCtrl_q[FMAC_CONV_RATE_BIT];
    wire [1:0] convRes = convCtrl_q[FMAC_CONV_RES_HI:FMAC_CONV_RES_LO];

    // Fault mask next value
    always_comb begin
        faultMask_d = faultMask_q;
        if (regReset) begin
            // Register reset restores default
            faultMask_d = FMAC_RST_FAULT_MASK;
        end else if (wrMask) begin
            // Host write
            faultMask_d = wrMaskVal;
        end
    end

    // Converter control next value
    always_comb begin
        convCtrl_d = convCtrl_q;
        if (regReset) begin
            // Register reset restores default
            convCtrl_d = FMAC_RST_CONV_CTRL;
        end else begin
            if (seqBus.oneShotEnd) begin
                // One-shot pass finished: converter turns off
                convCtrl_d[FMAC_CONV_EN_BIT] = 1'b0;
            end
            if (watchdogExpire) begin
                // Watchdog clears only the enable bit
                convCtrl_d[FMAC_CONV_EN_BIT] = 1'b0;
            end
            if (wrCtrl) begin
                // Host write; beats a one-shot end in the same cycle, but a watchdog still clears enable
                convCtrl_d = wrCtrlVal;
                if (watchdogExpire) begin
                    convCtrl_d[FMAC_CONV_EN_BIT] = 1'b0;
                end
            end
        end
    end

    // Channel disable next value
    always_comb begin
        chOff_d = chOff_q;
        if (regReset) begin
            // Register reset: all channels converted
            chOff_d = FMAC_RST_CH_OFF;
        end else if (wrChOff) begin
            // Host write
            chOff_d = wrChOffVal;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb begin
        rdData_d = rdData_q;
        if (regRdEn) begin
            if (selMask) begin
                rdData_d = faultMask_q & FMAC_IMPL_FAULT_MASK;
            end else if (selCtrl) begin
                rdData_d = convCtrl_q & FMAC_IMPL_CONV_CTRL;
            end else if (selChOff) begin
                rdData_d = chOff_q & FMAC_IMPL_CH_OFF;
            end else begin
                rdData_d = FMAC_ZERO_BYTE;
            end
        end
    end

    // Combine every gated source onto one pulse
    always_comb begin
        intPulse_d = irqInputOvervolt | irqThermal | irqBatteryOvervolt
                   | irqSafetyTimer | irqSystemShort | irqStepdown
                   | irqConvDone;
    end

    // Register bank flip-flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            faultMask_q <= FMAC_RST_FAULT_MASK;
            convCtrl_q <= FMAC_RST_CONV_CTRL;
            chOff_q <= FMAC_RST_CH_OFF;
            rdData_q <= FMAC_ZERO_BYTE;
        end else begin
            faultMask_q <= faultMask_d;
            convCtrl_q <= convCtrl_d;
            chOff_q <= chOff_d;
            rdData_q <= rdData_d;
        end
    end

    // Edge history and interrupt pulse
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            faultPrev_q <= 5'h00;
            stepdownPrev_q <= 1'b0;
            intPulse_q <= 1'b0;
        end else begin
            faultPrev_q <= faultNow;
            stepdownPrev_q <= stepdownOutputFaultStatus;
            intPulse_q <= intPulse_d;
        end
    end

    // Control to the sequencer
    assign seqBus.enable = convEn;
    assign seqBus.oneShot = convRate;
    assign seqBus.chOff = chOff_q;

    // Scan sequencer
    fmac_seq fmac_seq_i (
        .mclk(mclk),
        .nrst(nrst),
        .ctl(seqBus),
        .convDone(convDone),
        .convStart(convStart),
        .convChannel(convChannel)
    );

    // Outputs
    assign regRdData = rdData_q;
    assign convResolution = fmac_res_t'(convRes);
    assign convEnabled = convEn;
    assign convOneShot = convRate;
    assign convPassDone = seqBus.passDone;
    assign intPulse = intPulse_q;
endmodule
